// File: ctu_channel.sv
// Purpose: One counter/timer channel with prescaler, down counter and reload
// Assumes: i_trigger is already synchronised to i_clock
// Notes: A time constant of zero counts 256 steps
`timescale 1ns/1ps
module ctu_channel (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr_ctrl,
  input wire logic i_wr_tc,
  input wire logic [7:0] i_wdata,
  input wire logic i_trigger,
  output logic o_tc_pending,
  output logic o_int_enabled,
  output logic [7:0] o_count,
  output logic o_zero,
  output logic o_zero_out
);

  ctu_pkg::ctu_ctrl_t ctrl_q, ctrl_d; // Control word
  logic [7:0] tc_q, tc_d;             // Time constant
  logic [7:0] count_q, count_d;       // Down counter
  logic [7:0] pre_q, pre_d;           // Prescaler
  logic run_q, run_d;                 // Channel counting
  logic tc_pend_q, tc_pend_d;         // Time constant expected next
  logic zout_q, zout_d;               // Zero-count output level
  logic zero_q, zero_d;               // Zero-count event pulse
  logic trig_prev_q, trig_prev_d;     // Last trigger level for edge detect

  // Next-state logic for the channel
  always_comb begin
    logic step;
    logic edge_seen;
    ctu_pkg::ctu_ctrl_t wctrl;
    step = 1'b0;
    edge_seen = 1'b0;
    wctrl = ctu_pkg::ctu_ctrl_t'(i_wdata);
    ctrl_d = ctrl_q;
    tc_d = tc_q;
    count_d = count_q;
    pre_d = pre_q;
    run_d = run_q;
    tc_pend_d = tc_pend_q;
    zout_d = zout_q;
    zero_d = 1'b0;
    trig_prev_d = i_trigger;
    // Active edge as selected by the control word
    edge_seen = ctrl_q.rising ? (i_trigger & ~trig_prev_q) : (~i_trigger & trig_prev_q);
    if (run_q) begin
      if (ctrl_q.counter_mode) begin
        step = edge_seen;
      end else begin
        // Prescaler divides the system clock before the counter moves
        if (pre_q == (ctrl_q.pre256 ? ctu_pkg::PRE_LAST_256 : ctu_pkg::PRE_LAST_16)) begin
          pre_d = '0;
          step = 1'b1;
        end else begin
          pre_d = pre_q + 8'h01;
        end
      end
    end
    if (step) begin
      if (count_q == ctu_pkg::COUNT_LAST) begin
        // Zero reached, reload and keep going
        count_d = tc_q;
        zero_d = 1'b1;
        zout_d = ~zout_q;
      end else begin
        count_d = count_q - 8'h01;
      end
    end
    // A time-constant write overrides counting in the same cycle
    if (i_wr_ctrl) begin
      ctrl_d = wctrl;
      tc_pend_d = wctrl.tc_follows;
      if (wctrl.sw_reset) begin
        run_d = 1'b0; // Software reset stops until a new constant
        pre_d = '0;
      end
    end else if (i_wr_tc) begin
      tc_d = i_wdata;
      count_d = i_wdata;
      pre_d = '0;
      tc_pend_d = 1'b0;
      run_d = 1'b1;
    end
  end

  // Channel state registers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= ctu_pkg::ctu_ctrl_t'(ctu_pkg::CTRL_RESET);
      tc_q <= ctu_pkg::TC_RESET;
      count_q <= ctu_pkg::COUNT_RESET;
      pre_q <= '0;
      run_q <= 1'b0;
      tc_pend_q <= 1'b0;
      zout_q <= 1'b0;
      zero_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      tc_q <= tc_d;
      count_q <= count_d;
      pre_q <= pre_d;
      run_q <= run_d;
      tc_pend_q <= tc_pend_d;
      zout_q <= zout_d;
      zero_q <= zero_d;
      trig_prev_q <= trig_prev_d;
    end
  end

  // Outputs come straight from registers
  assign o_tc_pending = tc_pend_q;
  assign o_int_enabled = ctrl_q.int_en;
  assign o_count = count_q;
  assign o_zero = zero_q;
  assign o_zero_out = zout_q;

endmodule

// File: ctu_chk.sv
// Purpose: Port-level checks on the counter/timer unit
// Assumes: One clock, async active-high reset
// Notes: Pin inputs reach the logic through two sync flops
`timescale 1ns/1ps
module ctu_chk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic i_chain_enable_in,
  input wire logic o_chain_enable_out,
  input wire logic i_opcode_fetch_cycle_n,
  input wire logic i_io_request_strobe_n,
  input wire logic i_memory_request_strobe_n,
  input wire logic [7:0] i_data_bus,
  input wire logic [7:0] o_data_bus,
  input wire logic o_data_bus_oe,
  input wire logic o_int_request_n,
  input wire logic o_nmi_request_n,
  input wire logic i_line_clock_in,
  input wire logic i_display_pulse,
  input wire logic i_expansion_pulse,
  input wire logic [3:0] o_zero_count
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Start of a vector drive
  sequence s_oe_start;
    !o_data_bus_oe ##1 o_data_bus_oe;
  endsequence
  // Acknowledge pins two edges back, the sync delay
  sequence s_ack_seen;
    $past(!i_opcode_fetch_cycle_n && !i_io_request_strobe_n, 2);
  endsequence
  a_nmi_unused: assert property (o_nmi_request_n) else $error("nmi request asserted");
  a_read_idle: assert property (!i_read |=> o_rdata == ctu_pkg::READ_IDLE) else $error("rdata not idle");
  a_read_unmapped: assert property (i_read && !(i_addr inside {[ctu_pkg::ADDR_CH0:ctu_pkg::ADDR_CH3]})
    |=> o_rdata == ctu_pkg::READ_IDLE) else $error("unmapped read gave data");
  a_vector_alone: assert property (o_data_bus_oe |-> !o_chain_enable_out) else $error("vector with chain open");
  a_vector_form: assert property (s_oe_start |-> !o_data_bus[0] ##1 (!o_data_bus_oe || $stable(o_data_bus)))
    else $error("vector malformed or moving");
  a_ack_cause: assert property (o_data_bus_oe |-> s_ack_seen) else $error("vector outside acknowledge");
  a_request_chain: assert property (!o_int_request_n |-> !o_chain_enable_out && $past(i_chain_enable_in, 2))
    else $error("request with chain wrong");
  a_chain_pass: assert property (o_chain_enable_out |-> $past(i_chain_enable_in, 2) && o_int_request_n)
    else $error("chain out without chain in");
  a_reset_clear: assert property ($fell(i_sys_rst) |-> o_zero_count == 4'h0 && o_int_request_n && !o_data_bus_oe)
    else $error("state after reset not clear");
endmodule

// File: ctu_cpu_model.sv
// Purpose: Processor model for acknowledge and return-op fetch cycles
// Assumes: Pins change just after a rising clock edge
// Notes: Idle data lines toggle each cycle so a stale byte never passes
`timescale 1ns/1ps
module ctu_cpu_model (
  input wire logic i_clock,
  input wire logic i_int_request_n,
  input wire logic i_data_oe,
  input wire logic [7:0] i_data_level,
  output logic o_opcode_fetch_cycle_n,
  output logic o_io_request_strobe_n,
  output logic o_memory_request_strobe_n,
  output logic [7:0] o_data
);
  logic [7:0] op = 8'h00; // Opcode on the bus during a fetch
  logic [7:0] pat = 8'h5A; // Released-bus pattern
  logic fetching = 1'b0;
  initial begin
    o_opcode_fetch_cycle_n = 1'b1;
    o_io_request_strobe_n = 1'b1;
    o_memory_request_strobe_n = 1'b1;
  end
  // Changing pattern while nobody drives
  always @(posedge i_clock) pat <= ~pat;
  assign o_data = fetching ? op : pat;
  // Acknowledge: fetch with the I/O strobe, memory strobe idle
  task automatic ack(output logic [7:0] v);
    v = 8'hFF;
    for (int n = 0; n < 20 && i_int_request_n !== 1'b0; n++) @(posedge i_clock);
    @(posedge i_clock);
    o_opcode_fetch_cycle_n <= 1'b0;
    o_io_request_strobe_n <= 1'b0;
    repeat (6) begin
      @(negedge i_clock);
      if (i_data_oe === 1'b1) v = i_data_level;
    end
    @(posedge i_clock);
    o_opcode_fetch_cycle_n <= 1'b1;
    o_io_request_strobe_n <= 1'b1;
    repeat (4) @(posedge i_clock);
  endtask
  // One memory opcode fetch
  task automatic fetch(input logic [7:0] b);
    @(posedge i_clock);
    op <= b;
    fetching <= 1'b1;
    o_opcode_fetch_cycle_n <= 1'b0;
    o_memory_request_strobe_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    o_opcode_fetch_cycle_n <= 1'b1;
    o_memory_request_strobe_n <= 1'b1;
    fetching <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask
  // Two-byte return op, fetched back to back
  task automatic return_from_interrupt_op();
    fetch(ctu_pkg::RETURN_OP_FIRST);
    fetch(ctu_pkg::RETURN_OP_SECOND);
    repeat (4) @(posedge i_clock);
  endtask
endmodule

// File: ctu_pkg.sv
// Purpose: Shared constants and types for the four-channel counter/timer unit
// Assumes: Processor bus pins reach the unit asynchronously and are synchronised inside
// Notes: Control word layout and channel addressing are common to the top and the channel
package ctu_pkg;

  // Channel count and data width
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned DATA_W = 8;

  // I/O addresses of the four channels
  localparam logic [7:0] ADDR_CH0 = 8'h0C;
  localparam logic [7:0] ADDR_CH3 = 8'h0F;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Two-byte return-from-interrupt opcode
  localparam logic [7:0] RETURN_OP_FIRST = 8'hED;
  localparam logic [7:0] RETURN_OP_SECOND = 8'h4D;

  // Prescaler terminal values for divide by 16 and by 256
  localparam logic [7:0] PRE_LAST_16 = 8'h0F;
  localparam logic [7:0] PRE_LAST_256 = 8'hFF;

  // Counter value at which the next decrement reaches zero
  localparam logic [7:0] COUNT_LAST = 8'h01;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TC_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [4:0] VECTOR_BASE_RESET = 5'h00;

  // Channel control word, bit 0 set marks a control word
  typedef struct packed {
    logic int_en;       // Interrupt on zero count
    logic counter_mode; // 1 counter, 0 timer
    logic pre256;       // Timer prescale 256, else 16
    logic rising;       // Counter active edge rising, else falling
    logic spare;        // Stored, no effect
    logic tc_follows;   // Next write is the time constant
    logic sw_reset;     // Stop the channel
    logic is_control;   // Marks a control word
  } ctu_ctrl_t;

  // Synchronised pin group
  typedef struct packed {
    logic fetch_n;   // Opcode fetch cycle, active low
    logic ioreq_n;   // I/O request strobe, active low
    logic memory_request_strobe_n;    // Memory request strobe, active low
    logic chain_in;  // Chain enable in, active high
    logic [3:0] trig; // Channel trigger inputs
    logic [7:0] data; // Processor data bus
  } ctu_pins_t;

endpackage

// File: ctu_top.sv
// What this block does
// - Four separately programmable counter/timer channels
// - Channel 0 wins interrupt priority
// - Each channel supplies its own vector
// - Eight-bit time constant and control registers
// - Readable down counter plus eight-bit prescaler
// - Timer prescale divides clock by 16/256
// - Counter mode, constant 1: interrupt per edge
// - Channels 0,1 divide line clock input
// - Channels 2,3 take display, expansion pulses
// - Fetch with I/O strobe means acknowledge
// - Only chain-in high, chain-out low drives vector
// - Chain out low until return op seen
// - Decode two-byte return op from fetches
// - Non-maskable request never asserted
// - Channels sit at I/O 0C to 0F
//
// Purpose: Counter/timer unit with vectored daisy-chain interrupts on an 8-bit processor bus
// Assumes: Processor pins are asynchronous to i_clock; the register port is synchronous
// Notes: Register port is sampled on i_clock; read data stand one cycle after the strobe
`timescale 1ns/1ps
module ctu_top (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_chain_enable_in,
  output logic o_chain_enable_out,
  input wire logic i_opcode_fetch_cycle_n,
  input wire logic i_io_request_strobe_n,
  input wire logic i_memory_request_strobe_n,
  input wire logic [7:0] i_data_bus,
  output logic [7:0] o_data_bus,
  output logic o_data_bus_oe,
  output logic o_int_request_n,
  output logic o_nmi_request_n,
  input wire logic i_line_clock_in,
  input wire logic i_display_pulse,
  input wire logic i_expansion_pulse,
  output logic [3:0] o_zero_count
);

  localparam int unsigned NCH = ctu_pkg::CHANNELS;

  // Highest-priority set bit, lowest index first
  function automatic logic [1:0] first_set(input logic [3:0] mask);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // Pin synchroniser, first stage is read only by the second
  ctu_pkg::ctu_pins_t pin_raw;
  ctu_pkg::ctu_pins_t sync1_q, sync2_q;
  // Reset value matches the idle pin levels; triggers idle low so no false edge follows reset
  localparam ctu_pkg::ctu_pins_t PINS_IDLE = '{fetch_n: 1'b1, ioreq_n: 1'b1, memory_request_strobe_n: 1'b1, chain_in: 1'b1,
    trig: 4'h0, data: 8'hFF};

  // Bus cycle tracking
  logic ack_prev_q, ack_prev_d;         // Acknowledge cycle seen last clock
  logic mfetch_prev_q, mfetch_prev_d;   // Memory opcode fetch seen last clock
  logic [7:0] op_byte_q, op_byte_d;     // Last opcode byte seen in a fetch
  logic seen_first_q, seen_first_d;     // First return-op byte just fetched
  logic return_from_interrupt_op_q, return_from_interrupt_op_d;                 // Return op decoded, one-cycle pulse

  // Interrupt state
  logic [3:0] pending_q, pending_d;     // Requests awaiting acknowledge
  logic [3:0] service_q, service_d;     // Channels in service
  logic drive_q, drive_d;               // Vector being driven
  logic [7:0] vec_out_q, vec_out_d;     // Vector on the data bus
  logic [4:0] vbase_q, vbase_d;         // Vector base shared by channels

  // Register port
  logic [7:0] rdata_q, rdata_d;

  // Channel wiring
  logic [3:0] wr_ctrl;
  logic [3:0] wr_tc;
  logic [3:0] tc_pend;
  logic [3:0] int_en;
  logic [3:0] zero_evt;
  logic [3:0] zero_out;
  logic [7:0] count [NCH];

  // Decoded bus conditions from synchronised pins
  logic fetch_act;
  logic ack_act;
  logic mfetch_act;
  logic chain_in;
  logic ch_hit;
  logic [1:0] ch_sel;
  logic vec_write;
  ctu_pkg::ctu_ctrl_t wr_word; // Write data seen as a control word

  // Channel triggers: line clock feeds 0 and 1, display 2, expansion 3
  assign pin_raw.fetch_n = i_opcode_fetch_cycle_n;
  assign pin_raw.ioreq_n = i_io_request_strobe_n;
  assign pin_raw.memory_request_strobe_n = i_memory_request_strobe_n;
  assign pin_raw.chain_in = i_chain_enable_in;
  assign pin_raw.trig = {i_expansion_pulse, i_display_pulse, i_line_clock_in, i_line_clock_in};
  assign pin_raw.data = i_data_bus;

  // Two-stage synchroniser on every pin input
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // Fetch with I/O strobe is the acknowledge; with memory strobe a normal fetch
  assign fetch_act = ~sync2_q.fetch_n;
  assign ack_act = fetch_act & ~sync2_q.ioreq_n;
  assign mfetch_act = fetch_act & ~sync2_q.memory_request_strobe_n;
  assign chain_in = sync2_q.chain_in;

  // Address decode for the channel block
  always_comb begin
    ch_hit = 1'b0;
    if (i_addr >= ctu_pkg::ADDR_CH0 && i_addr <= ctu_pkg::ADDR_CH3) begin
      ch_hit = 1'b1;
    end else begin
      ch_hit = 1'b0;
    end
  end
  assign ch_sel = 2'(i_addr - ctu_pkg::ADDR_CH0);
  assign wr_word = ctu_pkg::ctu_ctrl_t'(i_wdata);

  // Write routing: control word, time constant, or vector base
  always_comb begin
    wr_ctrl = '0;
    wr_tc = '0;
    vec_write = 1'b0;
    if (i_write && ch_hit) begin
      if (tc_pend[ch_sel]) begin
        wr_tc[ch_sel] = 1'b1;
      end else if (wr_word.is_control) begin
        wr_ctrl[ch_sel] = 1'b1;
      end else if (ch_sel == 2'd0) begin
        vec_write = 1'b1;
      end
    end
  end

  // Four identical channels
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    ctu_channel u_channel (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_wr_ctrl(wr_ctrl[g]),
      .i_wr_tc(wr_tc[g]),
      .i_wdata(i_wdata),
      .i_trigger(sync2_q.trig[g]),
      .o_tc_pending(tc_pend[g]),
      .o_int_enabled(int_en[g]),
      .o_count(count[g]),
      .o_zero(zero_evt[g]),
      .o_zero_out(zero_out[g])
    );
  end

  // Opcode watcher: latch each fetched byte, decode at the end of the fetch
  always_comb begin
    mfetch_prev_d = mfetch_act;
    op_byte_d = op_byte_q;
    seen_first_d = seen_first_q;
    return_from_interrupt_op_d = 1'b0;
    if (mfetch_act) begin
      op_byte_d = sync2_q.data; // Keeps the last sample taken while the strobe held
    end
    if (mfetch_prev_q && !mfetch_act) begin
      // Any byte other than the second op byte breaks the pair
      if (seen_first_q && op_byte_q == ctu_pkg::RETURN_OP_SECOND) begin
        return_from_interrupt_op_d = 1'b1;
        seen_first_d = 1'b0;
      end else begin
        seen_first_d = (op_byte_q == ctu_pkg::RETURN_OP_FIRST);
      end
    end
  end

  // Opcode watcher registers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mfetch_prev_q <= 1'b0;
      op_byte_q <= '0;
      seen_first_q <= 1'b0;
      return_from_interrupt_op_q <= 1'b0;
    end else begin
      mfetch_prev_q <= mfetch_prev_d;
      op_byte_q <= op_byte_d;
      seen_first_q <= seen_first_d;
      return_from_interrupt_op_q <= return_from_interrupt_op_d;
    end
  end

  // Interrupt state: request, acknowledge and return handling
  always_comb begin
    logic [1:0] win;
    logic [1:0] done;
    logic [3:0] clr_sw;
    win = first_set(pending_q);
    done = first_set(service_q);
    clr_sw = '0;
    pending_d = pending_q;
    service_d = service_q;
    drive_d = drive_q;
    vec_out_d = vec_out_q;
    vbase_d = vbase_q;
    ack_prev_d = ack_act;
    if (vec_write) begin
      vbase_d = i_wdata[ctu_pkg::DATA_W-1 -: $bits(vbase_q)];
    end
    // Acknowledge taken once, at the start of the cycle
    if (ack_act && !ack_prev_q && chain_in && (pending_q != '0)) begin
      pending_d[win] = 1'b0;
      service_d[win] = 1'b1;
      vec_out_d = {vbase_q, win, 1'b0};
      drive_d = 1'b1;
    end
    if (!ack_act) begin
      drive_d = 1'b0;
    end
    // Return op releases the highest-priority (lowest-numbered) channel in service while chain in is high
    if (return_from_interrupt_op_q && chain_in && (service_q != '0)) begin
      service_d[done] = 1'b0;
    end
    // Software reset of a channel drops its request
    for (int i = 0; i < NCH; i++) begin
      clr_sw[i] = wr_ctrl[i] & wr_word.sw_reset;
    end
    pending_d = pending_d & ~clr_sw;
    // A new zero count wins over any clear in the same cycle
    pending_d = pending_d | (zero_evt & int_en);
  end

  // Interrupt state registers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pending_q <= '0;
      service_q <= '0;
      drive_q <= 1'b0;
      vec_out_q <= '0;
      vbase_q <= ctu_pkg::VECTOR_BASE_RESET;
      ack_prev_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
      service_q <= service_d;
      drive_q <= drive_d;
      vec_out_q <= vec_out_d;
      vbase_q <= vbase_d;
      ack_prev_q <= ack_prev_d;
    end
  end

  // Read data: counter of the addressed channel, zero otherwise
  always_comb begin
    rdata_d = ctu_pkg::READ_IDLE;
    if (i_read && ch_hit) begin
      rdata_d = count[ch_sel];
    end
  end

  // Read data register, holds a value only in the cycle after the strobe
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= ctu_pkg::READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // Request only while no channel of this unit is in service and chain allows
  assign o_int_request_n = ~(chain_in && (pending_q != '0) && (service_q == '0));

  // Chain passes through only with nothing pending or in service
  assign o_chain_enable_out = chain_in && (pending_q == '0) && (service_q == '0);

  // Vector driven only during the acknowledge this unit won
  assign o_data_bus_oe = drive_q & ack_act;
  assign o_data_bus = vec_out_q;

  // Non-maskable request is never used
  assign o_nmi_request_n = 1'b1;

  // Zero-count outputs; 0 and 1 serve as serial line clocks
  assign o_zero_count = zero_out;

endmodule

// File: ctu_top_tb_top.sv
// Purpose: Self-checking bench for the counter/timer unit
// Assumes: Processor side comes from ctu_cpu_model
// Notes: Timer periods are timed between o_zero_count toggles
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module ctu_top_tb_top;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic chain_in = 1'b1; // Upstream chain open
  logic [2:0] trg = 3'b000; // Expansion, display, line clock
  logic [7:0] o_rdata, dut_bus, cpu_bus, bus_level, vec, rd_v;
  logic oe, chain_out, int_n, nmi_n, fetch_n, ioreq_n, memory_request_strobe_n;
  logic [3:0] zero, zsav;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  // Unit drives the bus only while enabled
  assign bus_level = oe ? dut_bus : cpu_bus;
  ctu_top u_ctu_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_chain_enable_in(chain_in),
    .o_chain_enable_out(chain_out), .i_opcode_fetch_cycle_n(fetch_n), .i_io_request_strobe_n(ioreq_n),
    .i_memory_request_strobe_n(memory_request_strobe_n), .i_data_bus(bus_level), .o_data_bus(dut_bus), .o_data_bus_oe(oe),
    .o_int_request_n(int_n), .o_nmi_request_n(nmi_n), .i_line_clock_in(trg[0]), .i_display_pulse(trg[1]),
    .i_expansion_pulse(trg[2]), .o_zero_count(zero));
  ctu_cpu_model u_ctu_cpu_model (.i_clock(i_clock), .i_int_request_n(int_n), .i_data_oe(oe),
    .i_data_level(bus_level), .o_opcode_fetch_cycle_n(fetch_n), .o_io_request_strobe_n(ioreq_n),
    .o_memory_request_strobe_n(memory_request_strobe_n), .o_data(cpu_bus));
  initial forever #25 i_clock = ~i_clock;
  // Hang guard, far above the longest timer measurement
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 rd_v = o_rdata;
    `CHK(rd_v, e)
  endtask
  // Pulse selected trigger pins, long enough for the synchroniser
  task automatic pulse(input logic [2:0] m);
    @(posedge i_clock);
    trg <= m;
    repeat (4) @(posedge i_clock);
    trg <= 3'b000;
    repeat (4) @(posedge i_clock);
  endtask
  task automatic wait_tgl(output int c);
    logic z;
    z = zero[0];
    c = 0;
    while (zero[0] === z && c < 600) begin
      @(negedge i_clock);
      c++;
    end
  endtask
  task automatic set_chain(input logic v);
    @(posedge i_clock);
    chain_in <= v;
    repeat (4) @(posedge i_clock);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    `CHK(zero, 4'h0)
    `CHK(int_n, 1'b1)
    `CHK(nmi_n, 1'b1)
    `CHK(chain_out, 1'b1)
    rdc(8'h0E, ctu_pkg::COUNT_RESET);
    wr(8'h10, 8'h55);
    rdc(8'h10, ctu_pkg::READ_IDLE);
    // Channel 1 counts falling line-clock edges
    wr(8'h0D, 8'h45);
    wr(8'h0D, 8'h05);
    rdc(8'h0D, 8'h05);
    pulse(3'b001);
    pulse(3'b001);
    rdc(8'h0D, 8'h03);
    // Timer periods for both prescale ratios
    for (int k = 0; k < 2; k++) begin
      wr(8'h0C, 8'h03);
      wr(8'h0C, k ? 8'h25 : 8'h05);
      wr(8'h0C, k ? 8'h01 : 8'h02);
      wait_tgl(n);
      wait_tgl(n);
      `CHK(n, k ? 256 : 32)
    end
    wr(8'h0C, 8'h03);
    zsav = zero;
    repeat (300) @(negedge i_clock);
    `CHK(zero, zsav)
    // Channels 2 and 3 interrupt together; channel 2 wins
    wr(8'h0C, 8'hA8);
    wr(8'h0E, 8'hD5);
    wr(8'h0E, 8'h01);
    wr(8'h0F, 8'hD5);
    wr(8'h0F, 8'h01);
    pulse(3'b110);
    `CHK(zero[3:2], 2'b11)
    `CHK(int_n, 1'b0)
    `CHK(chain_out, 1'b0)
    u_ctu_cpu_model.ack(vec);
    `CHK(vec, 8'hAC)
    `CHK(int_n, 1'b1)
    u_ctu_cpu_model.return_from_interrupt_op();
    `CHK(int_n, 1'b0)
    u_ctu_cpu_model.ack(vec);
    `CHK(vec, 8'hAE)
    u_ctu_cpu_model.return_from_interrupt_op();
    `CHK(chain_out, 1'b1)
    // Closed chain holds the request back and blocks release
    set_chain(1'b0);
    pulse(3'b110);
    `CHK(int_n, 1'b1)
    // Software reset drops the channel 3 request; the final open chain proves it
    wr(8'h0F, 8'h03);
    set_chain(1'b1);
    u_ctu_cpu_model.ack(vec);
    `CHK(vec, 8'hAC)
    set_chain(1'b0);
    u_ctu_cpu_model.return_from_interrupt_op();
    set_chain(1'b1);
    `CHK(chain_out, 1'b0)
    u_ctu_cpu_model.return_from_interrupt_op();
    `CHK(chain_out, 1'b1)
    stop_test();
  end
endmodule
bind ctu_top ctu_chk u_ctu_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_chain_enable_in(i_chain_enable_in),
  .o_chain_enable_out(o_chain_enable_out), .i_opcode_fetch_cycle_n(i_opcode_fetch_cycle_n),
  .i_io_request_strobe_n(i_io_request_strobe_n), .i_memory_request_strobe_n(i_memory_request_strobe_n),
  .i_data_bus(i_data_bus), .o_data_bus(o_data_bus), .o_data_bus_oe(o_data_bus_oe),
  .o_int_request_n(o_int_request_n), .o_nmi_request_n(o_nmi_request_n), .i_line_clock_in(i_line_clock_in),
  .i_display_pulse(i_display_pulse), .i_expansion_pulse(i_expansion_pulse), .o_zero_count(o_zero_count));
